//--- design/prd_pkg.sv
/*
  Constants, field layouts and carrier structs for the parameter destination router.
  Assumes one 50 MHz system clock; everything here is shared by the router and its bench.
  // Function
  // - Accept pointers only from 0.00 to 21.51
  // - Missing destination: discard the output
  // - Protected destination: discard, leave unchanged
  // - Bit output writes exactly 0 or 1
  // - Non-bit to non-bit: pct times max over 100%
  // - Two reference destinations use maximum-reference scaling
  // - Non-bit to bit: 0 below half, else 1
  // - Duplicate destinations raise trip, blocked reset
  // - New routing takes effect only at drive reset
  // - Old destination zeroed, defaulted, or kept on card
  // - Speed references every 4 ms, else 250 us
  // - Analog fast speed needs all listed conditions
  // - Sliding window filter on analog input 1
  // - Fast mode scales with single multiplication
  // - Module hard speed writes copy to hard reference
  // - Encoder direct only with matching maximum, unity scale
  // - Encoder pulses dropped at reference limits
  // - Torque fast only from analog 2/3 voltage mode
*/
package prd_pkg;
  localparam int NCH = 4;
  // Register map (byte offsets)
  localparam logic [7:0] OFS_PTR_SHD = 8'h00;
  localparam logic [7:0] OFS_PTR_ACT = 8'h10;
  localparam logic [7:0] OFS_CFG = 8'h20;
  localparam logic [7:0] OFS_STAT = 8'h24;
  // Pointer layout {menu, parameter}, both binary
  localparam logic [7:0] PTR_MENU_MAX = 8'h15;
  localparam logic [7:0] PTR_PAR_MAX = 8'h63;
  localparam logic [7:0] PTR_LAST_PAR = 8'h33;
  localparam logic [15:0] PTR_NONE = 16'h0000;
  localparam logic [15:0] PTR_REF_A = 16'h0124;
  localparam logic [15:0] PTR_REF_B = 16'h0125;
  localparam logic [7:0] MENU_SLOT_LO = 8'h0F;
  localparam logic [7:0] MENU_SLOT_HI = 8'h11;
  // Menu that owns each destination selector
  localparam logic [7:0] CH_MENU [NCH] = '{8'h07, 8'h08, 8'h0F, 8'h11};
  // Scaling
  localparam logic [31:0] PCT_FULL = 32'h0000_2710;
  localparam logic [15:0] PCT_HALF = 16'h1388;
  localparam logic [15:0] ENC_UNITY = 16'h03E8;
  // Old-destination handling on a routing change
  localparam logic [1:0] KIND_ZERO = 2'h0;
  localparam logic [1:0] KIND_DFLT = 2'h1;
  localparam logic [1:0] KIND_CARD = 2'h2;
  // Config bit positions and reset value
  localparam int CFG_VOLT = 0;
  localparam int CFG_ZOFS = 1;
  localparam int CFG_BIPOL = 2;
  localparam int CFG_MIN0 = 3;
  localparam int CFG_SKIP0 = 4;
  localparam int CFG_JOGOFF = 5;
  localparam int CFG_FFOFF = 6;
  localparam int CFG_MODSRC = 7;
  localparam int CFG_AI1SEL = 8;
  localparam int CFG_TRQAI = 9;
  localparam int CFG_WIN_LSB = 12;
  localparam logic [15:0] CFG_RST = 16'h407F;
  // Timing
  localparam int CLK_MHZ = 50;
  localparam int FAST_PERIOD_US = 250;
  localparam int NORM_PERIOD_MS = 4;
  localparam int FAST_CYC_DEF = FAST_PERIOD_US * CLK_MHZ;
  localparam int NORM_DIV = NORM_PERIOD_MS * 1000 / FAST_PERIOD_US;
  localparam int HIST = 16;

  typedef struct packed {
    logic        is_bit;
    logic        bit_val;
    logic [15:0] pct;
  } prd_func_t;

  typedef struct packed {
    logic        exists;
    logic        prot;
    logic        is_bit;
    logic [15:0] max;
  } prd_attr_t;

  typedef struct packed {
    logic        valid;
    logic        dflt;
    logic [15:0] addr;
    logic [15:0] data;
  } prd_wr_t;
endpackage

//--- design/prd_param_routing_conflict_trip_router.sv
/*
  Destination router: scales function outputs onto parameters, checks for
  duplicate destinations, and paces speed, hard speed and torque sampling.
  Assumes every input comes from logic on clk_sys_in and that the parameter
  database answers attr_in combinationally for attr_addr_out.
*/
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/10ps
module prd_param_routing_conflict_trip_router #(
  parameter int FAST_CYC = prd_pkg::FAST_CYC_DEF
) (
  input  wire logic                    clk_sys_in,
  input  wire logic                    rst_n_in,
  input  wire logic [7:0]              reg_addr_in,
  input  wire logic [15:0]             reg_wdata_in,
  input  wire logic                    reg_wr_in,
  input  wire logic                    reg_rd_in,
  output logic [15:0]                  reg_rdata_out,
  input  wire logic                    drive_reset_in,
  input  wire logic [1:0]              load_kind_in,
  input  wire prd_pkg::prd_func_t      func_in [prd_pkg::NCH],
  output logic [15:0]                  attr_addr_out,
  input  wire prd_pkg::prd_attr_t      attr_in,
  output prd_pkg::prd_wr_t             wr_out,
  input  wire logic [15:0]             ref_max_in,
  input  wire logic [15:0]             ai1_in,
  input  wire logic [15:0]             ai2_in,
  input  wire logic [15:0]             mod_speed_in,
  input  wire logic [15:0]             mod_hard_in,
  input  wire logic                    mod_hard_wr_in,
  input  wire logic [15:0]             enc_max_in,
  input  wire logic [15:0]             enc_scale_in,
  input  wire logic [15:0]             enc_delta_in,
  output logic [15:0]                  ai1_filt_out,
  output logic [15:0]                  speed_ref_out,
  output logic [15:0]                  hard_ref_out,
  output logic                         speed_smp_out,
  output logic                         hard_smp_out,
  output logic                         torque_smp_out,
  output logic                         routing_conflict_trip_out
);
  localparam int N = prd_pkg::NCH;
  typedef enum logic [0:0] {ST_LOOK = 1'b0, ST_EVAL = 1'b1} prd_state_t;

  logic [15:0]        shd_r [N];
  logic [15:0]        act_r [N];
  logic [15:0]        old_r [N];
  logic [N-1:0]       clr_pend_r;
  logic [N-1:0]       chk;
  logic [N-1:0]       ref_route;
  logic [N-1:0]       done;
  logic [1:0]         kind_r;
  logic [15:0]        cfg_r;
  prd_state_t         st_r;
  logic [1:0]         ch_r;
  logic               clr_sel_r;
  logic               conflict;
  logic [15:0]        tb_cnt_r;
  logic [3:0]         sub_r;
  logic [15:0]        hist_r [prd_pkg::HIST];
  logic [19:0]        win_sum;
  prd_pkg::prd_wr_t   wr_nxt;

  // Register decode
  wire       wr_shd   = reg_wr_in && reg_addr_in[7:4] == prd_pkg::OFS_PTR_SHD[7:4];
  wire       wr_cfg   = reg_wr_in && reg_addr_in == prd_pkg::OFS_CFG;
  wire [1:0] idx      = reg_addr_in[3:2];
  wire [7:0] w_menu   = reg_wdata_in[15:8];
  wire [7:0] w_par    = reg_wdata_in[7:0];
  wire       ptr_ok   = w_menu <= prd_pkg::PTR_MENU_MAX && w_par <= prd_pkg::PTR_PAR_MAX &&
                        (w_menu != prd_pkg::PTR_MENU_MAX || w_par <= prd_pkg::PTR_LAST_PAR);

  // Per-selector pointer storage; shadow moves to active only at drive reset
  for (genvar i = 0; i < N; i++) begin : g_ch
    wire set_clr = drive_reset_in && shd_r[i] != act_r[i] && act_r[i] != prd_pkg::PTR_NONE;
    assign chk[i] = act_r[i] != prd_pkg::PTR_NONE &&
                    !(prd_pkg::CH_MENU[i] >= prd_pkg::MENU_SLOT_LO &&
                      prd_pkg::CH_MENU[i] <= prd_pkg::MENU_SLOT_HI);
    assign ref_route[i] = act_r[i] == prd_pkg::PTR_REF_A || act_r[i] == prd_pkg::PTR_REF_B;
    assign done[i] = st_r == ST_EVAL && clr_sel_r && ch_r == 2'(i);
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        shd_r[i] <= prd_pkg::PTR_NONE;
        act_r[i] <= prd_pkg::PTR_NONE;
        old_r[i] <= prd_pkg::PTR_NONE;
        clr_pend_r[i] <= 1'b0;
      end else begin
        if (wr_shd && idx == 2'(i) && ptr_ok) begin
          shd_r[i] <= reg_wdata_in;
        end
        if (drive_reset_in) begin
          act_r[i] <= shd_r[i];
        end
        if (set_clr) begin
          old_r[i] <= act_r[i];
        end
        // A new change beats completion of the previous clear
        clr_pend_r[i] <= set_clr | (clr_pend_r[i] & ~done[i]);
      end
    end
  end

  // Pairwise duplicate check across active destinations of selectors outside menus 15 to 17
  always_comb begin
    conflict = 1'b0;
    for (int i = 0; i < N; i++) begin
      for (int j = i + 1; j < N; j++) begin
        if (chk[i] && chk[j] && act_r[i] == act_r[j]) begin
          conflict = 1'b1;
        end
      end
    end
  end

  // Trip: set wins, reset only clears it once the conflict is gone
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      routing_conflict_trip_out <= 1'b0;
    end else begin
      routing_conflict_trip_out <= conflict | (routing_conflict_trip_out & ~drive_reset_in);
    end
  end

  // Load kind and config register
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      kind_r <= prd_pkg::KIND_ZERO;
      cfg_r <= prd_pkg::CFG_RST;
    end else begin
      if (drive_reset_in) begin
        kind_r <= load_kind_in;
      end
      if (wr_cfg) begin
        cfg_r <= reg_wdata_in;
      end
    end
  end

  // Scaling of the selected function output
  prd_pkg::prd_func_t fn;
  assign fn = func_in[ch_r];
  wire        spec    = attr_addr_out == prd_pkg::PTR_REF_A || attr_addr_out == prd_pkg::PTR_REF_B;
  wire [15:0] sc_max  = spec ? ref_max_in : attr_in.max;
  wire [31:0] prod    = {16'h0000, fn.pct} * {16'h0000, sc_max};
  wire [31:0] quo     = prod / prd_pkg::PCT_FULL;
  wire        half    = fn.pct >= prd_pkg::PCT_HALF;
  wire [15:0] val     = fn.is_bit ? {15'h0000, fn.bit_val} :
                        (attr_in.is_bit && !spec) ? {15'h0000, half} : quo[15:0];
  wire        dst_ok  = attr_addr_out != prd_pkg::PTR_NONE && attr_in.exists && !attr_in.prot;
  wire        skip    = clr_sel_r && kind_r == prd_pkg::KIND_CARD;
  wire [15:0] tgt     = clr_pend_r[ch_r] ? old_r[ch_r] : act_r[ch_r];

  always_comb begin
    wr_nxt.valid = st_r == ST_EVAL && dst_ok && !skip;
    wr_nxt.dflt = clr_sel_r && kind_r == prd_pkg::KIND_DFLT;
    wr_nxt.addr = attr_addr_out;
    wr_nxt.data = clr_sel_r ? 16'h0000 : val;
  end

  // Two-cycle scan: look up attributes, then write
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_r <= ST_LOOK;
      ch_r <= 2'h0;
      clr_sel_r <= 1'b0;
      attr_addr_out <= prd_pkg::PTR_NONE;
      wr_out <= '0;
    end else begin
      wr_out <= wr_nxt;
      unique case (st_r)
        ST_LOOK: begin
          attr_addr_out <= tgt;
          clr_sel_r <= clr_pend_r[ch_r];
          st_r <= ST_EVAL;
        end
        ST_EVAL: begin
          ch_r <= ch_r + 2'h1;
          st_r <= ST_LOOK;
        end
      endcase
    end
  end

  // One counter yields both ticks, so 4 ms always lands on a 250 us edge
  wire fast_tick = tb_cnt_r == 16'(FAST_CYC - 1);
  wire norm_tick = fast_tick && sub_r == 4'(prd_pkg::NORM_DIV - 1);
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tb_cnt_r <= 16'h0000;
      sub_r <= 4'h0;
    end else begin
      tb_cnt_r <= fast_tick ? 16'h0000 : tb_cnt_r + 16'h0001;
      sub_r <= fast_tick ? sub_r + 4'h1 : sub_r;
    end
  end

  // Fast-rate qualification
  wire [2:0] win      = cfg_r[prd_pkg::CFG_WIN_LSB +: 3];
  wire       vz       = cfg_r[prd_pkg::CFG_VOLT] && cfg_r[prd_pkg::CFG_ZOFS];
  wire       ana_ok   = |ref_route && vz && (cfg_r[prd_pkg::CFG_BIPOL] || cfg_r[prd_pkg::CFG_MIN0]) &&
                        cfg_r[prd_pkg::CFG_SKIP0] && cfg_r[prd_pkg::CFG_JOGOFF] &&
                        cfg_r[prd_pkg::CFG_FFOFF] && !(cfg_r[prd_pkg::CFG_AI1SEL] && win != 3'h0);
  wire       mod_src  = cfg_r[prd_pkg::CFG_MODSRC];
  wire       spd_fast = mod_src || ana_ok;
  wire       enc_dir  = enc_max_in == ref_max_in && enc_scale_in == prd_pkg::ENC_UNITY;
  wire       hrd_fast = mod_src || enc_dir || ana_ok;
  wire       trq_fast = cfg_r[prd_pkg::CFG_TRQAI] && vz;

  // Sample strobes
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      speed_smp_out <= 1'b0;
      hard_smp_out <= 1'b0;
      torque_smp_out <= 1'b0;
    end else begin
      speed_smp_out <= spd_fast ? fast_tick : norm_tick;
      hard_smp_out <= hrd_fast ? fast_tick : norm_tick;
      torque_smp_out <= trq_fast ? fast_tick : norm_tick;
    end
  end

  // Sliding window on analog input 1; window is 2^win fast ticks, capped at 16 entries
  always_comb begin
    win_sum = 20'h00000;
    for (int k = 0; k < prd_pkg::HIST; k++) begin
      if (k < (1 << win)) begin
        win_sum = win_sum + {4'h0, hist_r[k]};
      end
    end
  end

  for (genvar k = 0; k < prd_pkg::HIST; k++) begin : g_hist
    always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
      if (!rst_n_in) begin
        hist_r[k] <= 16'h0000;
      end else if (fast_tick) begin
        hist_r[k] <= (k == 0) ? ai1_in : hist_r[(k == 0) ? 0 : k - 1];
      end
    end
  end

  // Speed reference: module value when selected, else one multiply when fast, two stages otherwise
  wire [15:0] ai_sel  = cfg_r[prd_pkg::CFG_AI1SEL] ? ai1_filt_out : ai2_in;
  wire [31:0] ai_fast = {16'h0000, ai_sel} * {16'h0000, ref_max_in};
  wire [31:0] ai_pct  = ({16'h0000, ai_sel} * prd_pkg::PCT_FULL) >> 16;
  wire [31:0] ai_two  = ({16'h0000, ai_pct[15:0]} * {16'h0000, ref_max_in}) / prd_pkg::PCT_FULL;
  wire [15:0] spd_nxt = mod_src ? mod_speed_in : (spd_fast ? ai_fast[31:16] : ai_two[15:0]);

  // Encoder slaving, clamped so pulses past a limit are lost
  wire signed [16:0] h_sum = $signed({hard_ref_out[15], hard_ref_out}) + $signed({enc_delta_in[15], enc_delta_in});
  wire signed [16:0] h_hi  = $signed({1'b0, ref_max_in});
  wire signed [16:0] h_lo  = cfg_r[prd_pkg::CFG_BIPOL] ? -h_hi : 17'sh00000;
  wire [16:0]        h_cl  = h_sum > h_hi ? h_hi : (h_sum < h_lo ? h_lo : h_sum);

  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      ai1_filt_out <= 16'h0000;
      speed_ref_out <= 16'h0000;
      hard_ref_out <= 16'h0000;
    end else begin
      ai1_filt_out <= 16'(win_sum >> win);
      if (spd_fast ? fast_tick : norm_tick) begin
        speed_ref_out <= spd_nxt;
      end
      if (mod_hard_wr_in) begin
        hard_ref_out <= mod_hard_in;
      end else if (enc_dir && fast_tick) begin
        hard_ref_out <= h_cl[15:0];
      end
    end
  end

  // Read mux; data stands only in the cycle after the strobe
  wire [15:0] stat = {4'h0, clr_pend_r, 2'h0, enc_dir, trq_fast, hrd_fast, spd_fast,
                      conflict, routing_conflict_trip_out};
  wire [15:0] rd_mux = reg_addr_in[7:4] == prd_pkg::OFS_PTR_SHD[7:4] ? shd_r[idx] :
                       reg_addr_in[7:4] == prd_pkg::OFS_PTR_ACT[7:4] ? act_r[idx] :
                       reg_addr_in == prd_pkg::OFS_CFG ? cfg_r :
                       reg_addr_in == prd_pkg::OFS_STAT ? stat : 16'h0000;
  always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 16'h0000;
    end else begin
      reg_rdata_out <= reg_rd_in ? rd_mux : 16'h0000;
    end
  end

  // Checks
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rst_n_in);

  property p_range;
    wr_shd && !ptr_ok && idx == 2'h0 |=> $stable(shd_r[0]);
  endproperty
  a_range: assert property (p_range) else $error("out of range pointer stored");

  property p_absent;
    st_r == ST_EVAL && !attr_in.exists |=> !wr_out.valid;
  endproperty
  a_absent: assert property (p_absent) else $error("write to missing parameter");

  property p_prot;
    st_r == ST_EVAL && attr_in.prot |=> !wr_out.valid;
  endproperty
  a_prot: assert property (p_prot) else $error("write to protected parameter");

  property p_bit;
    st_r == ST_EVAL && dst_ok && !clr_sel_r && fn.is_bit |=> wr_out.valid && wr_out.data == {15'h0000, $past(fn.bit_val)};
  endproperty
  a_bit: assert property (p_bit) else $error("bit output not written as 0 or 1");

  property p_half;
    st_r == ST_EVAL && dst_ok && !clr_sel_r && !fn.is_bit && attr_in.is_bit && !spec
      |=> wr_out.data == {15'h0000, $past(fn.pct) >= 16'h1388};
  endproperty
  a_half: assert property (p_half) else $error("bit threshold wrong");

  property p_trip;
    conflict |=> routing_conflict_trip_out;
  endproperty
  a_trip: assert property (p_trip) else $error("conflict without trip");

  property p_hold;
    !drive_reset_in |=> $stable(act_r[1]);
  endproperty
  a_hold: assert property (p_hold) else $error("routing changed without reset");

  property p_clr;
    st_r == ST_EVAL && clr_sel_r && dst_ok && kind_r == prd_pkg::KIND_ZERO |=> wr_out.valid && wr_out.data == 16'h0000;
  endproperty
  a_clr: assert property (p_clr) else $error("old destination not zeroed");

  property p_norm;
    !spd_fast && !$past(spd_fast) ##0 $past(norm_tick) |-> speed_smp_out;
  endproperty
  a_norm: assert property (p_norm) else $error("normal speed sample missing");

  property p_align;
    norm_tick |-> fast_tick && tb_cnt_r == 16'(FAST_CYC - 1);
  endproperty
  a_align: assert property (p_align) else $error("ticks out of phase");

  property p_hard;
    mod_hard_wr_in |=> hard_ref_out == $past(mod_hard_in);
  endproperty
  a_hard: assert property (p_hard) else $error("module hard speed not copied");

  c_trip: cover property (drive_reset_in ##1 conflict ##1 routing_conflict_trip_out);
  c_clr: cover property (st_r == ST_EVAL && clr_sel_r ##1 wr_out.valid);
  c_fast: cover property (spd_fast && fast_tick ##1 speed_smp_out);
  c_enc: cover property (enc_dir && fast_tick && enc_delta_in != 16'h0000);
endmodule

//--- verification/prd_param_db.sv
/*
  Parameter database model standing at the router's far side.
  Assumes lookups by {menu, parameter} are answered in the same cycle.
*/
`timescale 1ns/10ps
module prd_param_db (
  input  wire logic [15:0]   addr_in,
  output prd_pkg::prd_attr_t attr_out
);
  // Fixed table; numbers not listed do not exist
  function automatic prd_pkg::prd_attr_t lookup(input logic [15:0] a);
    case (a)
      16'h0124, 16'h0125: return '{1'b1, 1'b0, 1'b0, 16'h0100};
      16'h0303: return '{1'b1, 1'b0, 1'b0, 16'h7FFF};
      16'h1401: return '{1'b1, 1'b0, 1'b0, 16'h03E8};
      16'h0E10: return '{1'b1, 1'b0, 1'b1, 16'h0001};
      16'h0C07: return '{1'b1, 1'b1, 1'b0, 16'h7FFF}; // Protected
      default: return '0; // Missing
    endcase
  endfunction

  assign attr_out = lookup(addr_in);
endmodule

//--- verification/tb_top.sv
/*
  Self-checking bench: register port, routed write scaling, old-destination
  handling, conflict trip, sample pacing and hard speed reference.
  Assumes prd_pkg, the router and the database model are compiled first.
*/
`timescale 1ns/10ps
module tb_top;
  localparam int FC = 20;
  logic               clk = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
  logic               drive_reset = 1'b0, mod_hard_wr = 1'b0, mon_en = 1'b0, align_chk = 1'b0;
  logic [1:0]         load_kind = 2'h0;
  logic [7:0]         reg_addr = 8'h00;
  logic [15:0]        reg_wdata = 16'h0000, ref_max = 16'h0100, ai1 = 16'h0000, ai2 = 16'h0000;
  logic [15:0]        mod_speed = 16'h0000, mod_hard = 16'h0000, enc_max = 16'h0000;
  logic [15:0]        enc_scale = 16'h0000, enc_delta = 16'h0000;
  logic [15:0]        reg_rdata, attr_addr, ai1_filt, speed_ref, hard_ref;
  logic               speed_smp, hard_smp, torque_smp, trip, clear_dflt;
  prd_pkg::prd_func_t func [prd_pkg::NCH];
  prd_pkg::prd_attr_t attr;
  prd_pkg::prd_wr_t   wr;
  int                 fails = 0, checks_done = 0, wr_cnt = 0, clear_seen = 0, clear_addr = 0;
  int                 seed = 32'h5995582B;
  int                 act [prd_pkg::NCH] = '{0, 0, 0, 0};
  int                 sh [prd_pkg::NCH] = '{0, 0, 0, 0};

  always #10 clk = ~clk;

  prd_param_routing_conflict_trip_router #(.FAST_CYC(FC)) prd_param_routing_conflict_trip_router_i (
    .clk_sys_in(clk), .rst_n_in(rst_n), .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata),
    .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_rdata_out(reg_rdata), .drive_reset_in(drive_reset),
    .load_kind_in(load_kind), .func_in(func), .attr_addr_out(attr_addr), .attr_in(attr), .wr_out(wr),
    .ref_max_in(ref_max), .ai1_in(ai1), .ai2_in(ai2), .mod_speed_in(mod_speed), .mod_hard_in(mod_hard),
    .mod_hard_wr_in(mod_hard_wr), .enc_max_in(enc_max), .enc_scale_in(enc_scale), .enc_delta_in(enc_delta),
    .ai1_filt_out(ai1_filt), .speed_ref_out(speed_ref), .hard_ref_out(hard_ref), .speed_smp_out(speed_smp),
    .hard_smp_out(hard_smp), .torque_smp_out(torque_smp), .routing_conflict_trip_out(trip));
  prd_param_db prd_param_db_i (.addr_in(attr_addr), .attr_out(attr));

  task automatic check(input bit ok, input string msg);
    checks_done++;
    if (!ok) begin
      $display("unexpected at %0t: %s", $time, msg);
      fails++;
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d, mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Register port master: one-cycle strobes, read data one cycle later
  task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  // Shadow copy follows only pointers the router may accept
  task automatic setp(input int c, input logic [15:0] p);
    bus_wr(8'(c * 4), p);
    if (p[15:8] <= 8'h15 && p[7:0] <= 8'h63 && !(p[15:8] == 8'h15 && p[7:0] > 8'h33))
      sh[c] = p;
  endtask

  task automatic dres(input logic [1:0] k);
    @(posedge clk);
    drive_reset <= 1'b1;
    load_kind <= k;
    @(posedge clk);
    drive_reset <= 1'b0;
    act = sh;
  endtask

  // Bench model of one channel's write; -1 means nothing may be written
  function automatic int exp_data(input int c);
    prd_pkg::prd_attr_t a;
    a = prd_param_db_i.lookup(16'(act[c]));
    if (act[c] == 0 || !a.exists || a.prot) return -1;
    if (func[c].is_bit) return int'(func[c].bit_val);
    if (act[c] == 16'h0124 || act[c] == 16'h0125) return func[c].pct * ref_max / prd_pkg::PCT_FULL;
    if (a.is_bit) return int'(func[c].pct >= 16'h1388);
    return func[c].pct * a.max / prd_pkg::PCT_FULL;
  endfunction

  // Each write is either a clear of the old destination or what the model says
  always @(posedge clk) begin : write_mon
    int e;
    e = -1;
    if (wr.valid === 1'b1 && clear_addr != 0 && wr.addr === 16'(clear_addr) && wr.data === 16'h0000) begin
      clear_seen = 1;
      clear_dflt = wr.dflt;
    end else if (mon_en && wr.valid === 1'b1) begin
      for (int c = 0; c < prd_pkg::NCH; c++)
        if (act[c] == wr.addr) e = exp_data(c);
      check(e >= 0 && wr.data === e[15:0], "routed write value");
      wr_cnt++;
    end
  end

  // A normal tick off the fast grid would slip the two rates apart
  always @(posedge clk)
    if (align_chk && torque_smp === 1'b1)
      check(speed_smp === 1'b1, "normal tick off fast grid");

  // New function outputs, settle, then watch three refreshes
  task automatic window(input int r);
    @(posedge clk);
    for (int k = 0; k < prd_pkg::NCH; k++)
      func[k] <= '{r % 3 == 2, $random(seed) % 2 != 0, r == 3 ? 16'h1387 : r == 4 ? 16'h1388 :
                   r == 0 ? 16'h2710 : 16'($unsigned($random(seed)) % 32'h2328 + 32'h03E8)};
    ref_max <= r == 1 ? 16'hFFFF : 16'h0100;
    repeat (12) @(posedge clk);
    wr_cnt = 0;
    mon_en <= 1'b1;
    repeat (24) @(posedge clk);
    mon_en <= 1'b0;
    @(posedge clk);
    check(wr_cnt >= 6, "routed writes missing");
  endtask

  // Interval between the second and third pulse, so a mode change has settled
  task automatic gap(input int sel, output int n);
    int i;
    n = -1;
    for (int j = 0; j < 3; j++) begin
      for (i = 1; i < 1000; i++) begin
        @(posedge clk);
        #1;
        if ((sel == 0 ? speed_smp : sel == 1 ? hard_smp : torque_smp) === 1'b1) break;
      end
      n = i < 1000 ? i : -1;
    end
    if (n < 0) begin
      fails++;
      wrap_up();
    end
  endtask

  task automatic wait_hard(input logic [15:0] v);
    int i;
    for (i = 0; i < 8000 && hard_ref !== v; i++)
      @(posedge clk);
    if (i == 8000) begin
      fails++;
      wrap_up();
    end
    repeat (8 * FC) @(posedge clk);
    check(hard_ref === v, "hard reference value");
  endtask

  initial begin
    logic [15:0] d;
    int n;
    foreach (func[k])
      func[k] = '0;
    ai1 = 16'($random(seed));
    ai2 = 16'($random(seed));
    mod_speed = 16'($random(seed));
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    bus_rd(prd_pkg::OFS_CFG, d);
    check(d === prd_pkg::CFG_RST && trip === 1'b0, "reset state");
    setp(0, 16'h0124);
    setp(1, 16'h0303);
    setp(2, 16'h0E10);
    setp(3, 16'h0C07);
    setp(1, 16'h1534);
    setp(2, 16'h1600);
    bus_wr(8'h10, 16'h0303);
    for (int c = 0; c < 4; c++) begin
      bus_rd(8'(c * 4), d);
      check(d === sh[c][15:0], "pointer readback");
    end
    bus_rd(8'h10, d);
    check(d === 16'h0000, "active pointer before drive reset");
    bus_rd(8'h30, d);
    check(d === 16'h0000, "unmapped read");
    mon_en <= 1'b1;
    repeat (40) @(posedge clk);
    mon_en <= 1'b0;
    check(wr_cnt == 0, "write before drive reset");
    $display("test registers done");
    dres(2'h0);
    for (int r = 0; r < 6; r++)
      window(r);
    $display("test scaling done");
    for (int k = 0; k < 3; k++) begin
      func[1] <= '{1'b0, 1'b0, 16'h1388};
      repeat (10) @(posedge clk);
      clear_addr = act[1];
      clear_seen = 0;
      setp(1, act[1] == 16'h0303 ? 16'h1401 : 16'h0303);
      setp(3, k == 1 ? 16'h1233 : 16'h0C07);
      dres(2'(k));
      repeat (30) @(posedge clk);
      check(clear_seen == (k != 2) && (k == 2 || clear_dflt === (k == 1)), "old destination");
      window(k);
    end
    clear_addr = 0;
    $display("test old destination done");
    setp(0, 16'h0303);
    setp(1, 16'h0303);
    repeat (2) begin
      dres(2'h2);
      repeat (10) @(posedge clk);
      check(trip === 1'b1, "duplicate destination trip");
    end
    setp(1, 16'h1401);
    setp(2, 16'h0E10);
    setp(3, 16'h0E10);
    repeat (2) dres(2'h2);
    repeat (10) @(posedge clk);
    check(trip === 1'b0, "trip after conflict removed");
    $display("test conflict done");
    gap(0, n);
    check(n == 16 * FC, "normal speed period");
    setp(0, 16'h0124);
    dres(2'h2);
    gap(0, n);
    check(n == FC, "fast speed period");
    align_chk <= 1'b1;
    gap(2, n);
    align_chk <= 1'b0;
    check(n == 16 * FC, "normal torque period");
    bus_wr(prd_pkg::OFS_CFG, 16'h426F);
    gap(0, n);
    check(n == 16 * FC, "speed with skip bands");
    gap(2, n);
    check(n == FC, "fast torque period");
    bus_wr(prd_pkg::OFS_CFG, 16'h427E);
    gap(2, n);
    check(n == 16 * FC, "torque without voltage mode");
    $display("test sample rates done");
    bus_wr(prd_pkg::OFS_CFG, prd_pkg::CFG_RST);
    enc_max <= 16'h0100;
    enc_scale <= 16'h03E9;
    ref_max <= 16'h0100;
    mod_hard <= 16'h0042;
    mod_hard_wr <= 1'b1;
    @(posedge clk);
    mod_hard_wr <= 1'b0;
    wait_hard(16'h0042);
    bus_rd(prd_pkg::OFS_STAT, d);
    check(d[5] === 1'b0, "encoder direct with wrong scale");
    @(posedge clk);
    enc_scale <= 16'h03E8;
    repeat (4) @(posedge clk);
    bus_rd(prd_pkg::OFS_STAT, d);
    check(d[5] === 1'b1, "encoder direct mode");
    @(posedge clk);
    enc_delta <= 16'h0005;
    wait_hard(16'h0100);
    enc_delta <= 16'hFFFB;
    wait_hard(16'hFF00);
    bus_wr(prd_pkg::OFS_CFG, 16'h407B);
    wait_hard(16'h0000);
    check(ai1_filt === ai1, "analog 1 window average");
    check(speed_ref === 16'((ai2 * 32'h0000_0100) >> 16), "fast speed scaling");
    bus_wr(prd_pkg::OFS_CFG, 16'h40FB);
    gap(0, n);
    check(n == FC && speed_ref === mod_speed, "module speed reference");
    $display("test hard reference done");
    wrap_up();
  end
endmodule
